// File: include/sar_ctrl_pkg.sv
// Operation
// - warp when fast high, low-power low
// - normal when both selects equal, 600 kSPS
// - impulse mode powers down after each conversion
// - convert only after acquisition and start low
// - resolve 16 bits, MSB first
// - form code, then drop busy
// - new setting applies after one acquisition cycle
// - result has no pipeline delay
// - coding selectable by pin or register
// - twos complement is binary with MSB inverted
// - overrange saturates to max or min code
// - two pins pick four input ranges
// - register in use ignores mode, coding, range pins
// - write-only serial port loads configuration register
// - serial select high, pins select low: register
package sar_ctrl_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_KHZ        = 25000;   // 25 MHz core clock
  localparam int unsigned WARP_KSPS      = 750;     // fastest throughput
  localparam int unsigned NORMAL_KSPS    = 600;
  localparam int unsigned IMPULSE_KSPS   = 500;
  // least start-to-start spacing, rounded up to whole cycles
  localparam int unsigned WARP_CYCLES    = (CLK_KHZ + WARP_KSPS - 1) / WARP_KSPS;
  localparam int unsigned NORMAL_CYCLES  = (CLK_KHZ + NORMAL_KSPS - 1) / NORMAL_KSPS;
  localparam int unsigned IMPULSE_CYCLES = (CLK_KHZ + IMPULSE_KSPS - 1) / IMPULSE_KSPS;
  localparam int unsigned STALE_US       = 1000;    // warp calibration drift gap
  localparam int unsigned STALE_CYCLES   = STALE_US * (CLK_KHZ / 1000);
  localparam int unsigned ACQ_CYCLES     = 4;       // least acquisition length
  localparam int unsigned CFG_BITS       = 5;       // serial configuration word

  // ----------------------------------------------------------------
  // codes
  // ----------------------------------------------------------------
  localparam logic [15:0] CODE_MAX  = 16'hFFFF;
  localparam logic [15:0] CODE_MIN  = 16'h0000;
  localparam logic [15:0] CODE_MID  = 16'h8000;   // also MSB trial and MSB flip
  localparam logic [15:0] CODE_LSB  = 16'h0001;

  // ----------------------------------------------------------------
  // register map (AXI4-Lite, byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0]  ADDR_CONTROL = 8'h00;
  localparam logic [7:0]  ADDR_STATUS  = 8'h04;
  localparam logic [7:0]  ADDR_RESULT  = 8'h08;
  localparam logic [7:0]  ADDR_CONFIG  = 8'h0C;
  localparam int unsigned CTL_ENABLE   = 0;       // accept conversion starts
  localparam int unsigned CTL_DISCARD  = 1;       // drop stale warp results from the fifo
  localparam logic [1:0]  CONTROL_RESET = 2'h1;
  localparam logic [1:0]  RESP_OKAY    = 2'h0;
  localparam logic [1:0]  RESP_SLVERR  = 2'h2;
  localparam int unsigned FIFO_DEPTH   = 4;
  localparam int unsigned FIFO_WIDTH   = 17;      // stale flag and code

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic bipolar;        // bipolar range
    logic span_double;    // 10 V span
    logic warp;           // high-speed select
    logic impulse;        // low-power select
    logic offset_binary;  // 1 straight binary, 0 twos complement
  } cfg_s;
  localparam cfg_s CFG_RESET = 5'h00;

  typedef enum logic [2:0] {
    MODE_NORMAL  = 3'b001,
    MODE_WARP    = 3'b010,
    MODE_IMPULSE = 3'b100
  } mode_e;

  typedef enum logic [2:0] {
    ST_ACQ  = 3'b001,
    ST_CONV = 3'b010,
    ST_DONE = 3'b100
  } state_e;

endpackage : sar_ctrl_pkg

// File: rtl/sar_adc_conversion_control.sv
// The register offsets and the AXI4-Lite slave port were chosen for this implementation.
`timescale 1ns/1ps

// ------------------------------------------------------------------
// result fifo
// ------------------------------------------------------------------
module sample_fifo #(
  parameter int unsigned WIDTH = 17,
  parameter int unsigned DEPTH = 4
) (
  input  wire logic             clk,
  input  wire logic             reset,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data,
  output logic [$clog2(DEPTH):0] level
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];   // storage
  logic [AW-1:0]    wr_ptr;        // next write slot
  logic [AW-1:0]    rd_ptr;        // oldest entry
  wire              push = in_valid & in_ready;
  wire              pop  = out_valid & out_ready;

  assign in_ready  = (level != DEPTH[AW:0]);
  assign out_valid = (level != '0);
  assign out_data  = mem[rd_ptr];

  // pointers and fill level
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      level  <= '0;
    end else begin
      if (push) wr_ptr <= AW'(wr_ptr + 1'b1);
      if (pop)  rd_ptr <= AW'(rd_ptr + 1'b1);
      level <= (AW+1)'(level + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop});
    end
  end

  // data array, no reset needed
  always_ff @(posedge clk) begin
    if (push) mem[wr_ptr] <= in_data;
  end
endmodule : sample_fifo

// ------------------------------------------------------------------
// conversion control
// ------------------------------------------------------------------
module sar_adc_conversion_control
  import sar_ctrl_pkg::*;
#(
  parameter int unsigned STALE_LIMIT = STALE_CYCLES  // warp idle gap, cycles
) (
  input  wire logic        clk,
  input  wire logic        reset,
  // conversion pins
  input  wire logic        convert_start_n,
  input  wire logic        high_speed_select,
  input  wire logic        low_power_select,
  input  wire logic        coding_select,
  input  wire logic        bipolar_select,
  input  wire logic        span_double_select,
  input  wire logic        serial_parallel_select,
  input  wire logic        pins_or_register_select,
  // serial configuration port
  input  wire logic        cfg_sck,
  input  wire logic        cfg_sdin,
  input  wire logic        cfg_cs_n,
  // analog core
  input  wire logic        comparator_keep,
  input  wire logic        overrange_high,
  input  wire logic        overrange_low,
  output logic [15:0]      dac_code,
  output logic             sampling,
  output logic             powered_down,
  output logic             range_bipolar,
  output logic             range_span_double,
  output logic             busy,
  output logic [15:0]      result_code,
  // AXI4-Lite slave
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  state_e      state;          // sequencer
  cfg_s        active;         // configuration in force
  cfg_s        serial_cfg;     // loaded over the serial port
  logic [15:0] step_mask;      // bit under test
  logic [15:0] sar_code;       // resolved raw code
  logic        over_hi;        // overrange caught at sample
  logic        over_lo;
  logic        stale;          // warp gap exceeded before this sample
  logic [31:0] since_start;    // saturating cycles since last start
  logic [7:0]  acq_cnt;        // saturating acquisition cycles
  logic        start_n_q;      // previous convert_start_n
  logic [1:0]  control;        // software control bits
  mode_e       active_mode;
  logic        sck_q;
  logic [CFG_BITS-1:0] cfg_shift;  // serial shift register
  logic [3:0]  cfg_count;      // bits seen in frame
  logic        cs_q;

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  wire   use_register = serial_parallel_select & ~pins_or_register_select;
  cfg_s  pin_cfg;
  assign pin_cfg = '{bipolar: bipolar_select, span_double: span_double_select,
                     warp: high_speed_select, impulse: low_power_select,
                     offset_binary: coding_select};
  cfg_s  sel_cfg;
  assign sel_cfg = use_register ? serial_cfg : pin_cfg;
  // one-hot mode from the two selects
  wire   [1:0] mode_pins = {sel_cfg.warp, sel_cfg.impulse};
  mode_e next_mode;
  assign next_mode = (mode_pins == 2'b10) ? MODE_WARP :
                     (mode_pins == 2'b01) ? MODE_IMPULSE :
                                            MODE_NORMAL;
  // throughput floor of the mode in force
  wire [31:0] period = (active_mode == MODE_WARP)    ? WARP_CYCLES :
                       (active_mode == MODE_IMPULSE) ? IMPULSE_CYCLES :
                                                       NORMAL_CYCLES;
  wire acq_done  = (state == ST_ACQ) && (acq_cnt >= ACQ_CYCLES[7:0]) &&
                   (since_start >= period);
  wire start_fall = start_n_q & ~convert_start_n;
  wire start     = start_fall & acq_done & control[CTL_ENABLE];
  wire last_step = (state == ST_CONV) && step_mask[0];
  // keep or drop the bit under test, then try the next one
  wire [15:0] kept = comparator_keep ? dac_code : (dac_code & ~step_mask);
  // saturation then coding
  wire [15:0] sat_code = over_hi ? CODE_MAX : over_lo ? CODE_MIN : sar_code;
  wire [15:0] final_code = active.offset_binary ? sat_code
                                                : (sat_code ^ CODE_MID);
  wire drop_stale = stale & control[CTL_DISCARD];
  wire fifo_in_ready;
  wire fifo_push = (state == ST_DONE) & ~drop_stale;
  wire finish    = (state == ST_DONE) & (fifo_in_ready | drop_stale);

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  // acquisition, bit trials, completion
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state     <= ST_ACQ;
      step_mask <= CODE_MIN;
      dac_code  <= CODE_MIN;
      sar_code  <= CODE_MIN;
      busy      <= 1'b0;
      sampling  <= 1'b1;
    end else begin
      case (state)
        ST_ACQ: begin
          if (start) begin
            state     <= ST_CONV;
            step_mask <= CODE_MID;   // MSB first
            dac_code  <= CODE_MID;
            busy      <= 1'b1;
            sampling  <= 1'b0;
          end
        end
        ST_CONV: begin
          dac_code  <= kept | (step_mask >> 1);
          step_mask <= step_mask >> 1;
          if (step_mask[0]) begin
            sar_code <= kept;
            state    <= ST_DONE;
          end
        end
        ST_DONE: begin
          // stalls here while the fifo is full, unless a stale result is being dropped
          if (finish) begin
            busy     <= 1'b0;        // code formed on this edge
            sampling <= 1'b1;
            state    <= ST_ACQ;
          end
        end
        default: state <= ST_ACQ;
      endcase
    end
  end

  // result output, held until the next completion
  always_ff @(posedge clk or posedge reset) begin
    if (reset) result_code <= CODE_MIN;
    else if (finish) result_code <= final_code;
  end

  // configuration applied at the sample edge, after one acquisition
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      active            <= CFG_RESET;
      active_mode       <= MODE_NORMAL;
      range_bipolar     <= 1'b0;
      range_span_double <= 1'b0;
    end else if (start) begin
      active            <= sel_cfg;
      active_mode       <= next_mode;
      range_bipolar     <= sel_cfg.bipolar;
      range_span_double <= sel_cfg.span_double;
    end
  end

  // impulse mode sleeps between conversions
  always_ff @(posedge clk or posedge reset) begin
    if (reset) powered_down <= 1'b0;
    else if (start) powered_down <= 1'b0;
    else if (finish && active_mode == MODE_IMPULSE) powered_down <= 1'b1;
  end

  // sample-instant flags and gap tracking
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      over_hi     <= 1'b0;
      over_lo     <= 1'b0;
      stale       <= 1'b0;
      since_start <= 32'h0000_0000;
      acq_cnt     <= 8'h00;
      start_n_q   <= 1'b1;
    end else begin
      start_n_q <= convert_start_n;
      if (start) begin
        over_hi     <= overrange_high;
        over_lo     <= overrange_low;
        // long gap in warp lets calibration drift
        stale       <= (next_mode == MODE_WARP) && (since_start >= STALE_LIMIT);
        since_start <= 32'h0000_0001;
      end else if (since_start < STALE_LIMIT) begin
        since_start <= since_start + 32'h0000_0001;
      end
      if (state != ST_ACQ) acq_cnt <= 8'h00;
      else if (acq_cnt != 8'hFF) acq_cnt <= acq_cnt + 8'h01;
    end
  end

  // ----------------------------------------------------------------
  // serial configuration port, write only
  // ----------------------------------------------------------------
  // MSB first on sck rise; a full frame loads on chip-select release
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      sck_q      <= 1'b0;
      cs_q       <= 1'b1;
      cfg_shift  <= '0;
      cfg_count  <= 4'h0;
      serial_cfg <= CFG_RESET;
    end else begin
      sck_q <= cfg_sck;
      cs_q  <= cfg_cs_n;
      if (cfg_cs_n) begin
        cfg_count <= 4'h0;
        if (!cs_q && cfg_count == CFG_BITS[3:0]) serial_cfg <= cfg_shift;
      end else if (cfg_sck && !sck_q) begin
        cfg_shift <= {cfg_shift[CFG_BITS-2:0], cfg_sdin};
        if (cfg_count != 4'hF) cfg_count <= cfg_count + 4'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // result fifo
  // ----------------------------------------------------------------
  wire                  fifo_out_valid;
  wire [FIFO_WIDTH-1:0] fifo_out_data;
  wire [2:0]            fifo_level;
  wire                  ar_take = s_axi_arvalid & s_axi_arready;
  wire                  rd_result = ar_take && (s_axi_araddr == ADDR_RESULT);

  sample_fifo #(.WIDTH(FIFO_WIDTH), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk       (clk),
    .reset     (reset),
    .in_valid  (fifo_push),
    .in_ready  (fifo_in_ready),
    .in_data   ({stale, final_code}),
    .out_valid (fifo_out_valid),
    .out_ready (rd_result),
    .out_data  (fifo_out_data),
    .level     (fifo_level)
  );

  // ----------------------------------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------------------------------
  logic       aw_got;       // address held
  logic       w_got;        // data held
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic       w_lane0;
  wire aw_take  = s_axi_awvalid & s_axi_awready;
  wire w_take   = s_axi_wvalid & s_axi_wready;
  wire aw_have  = aw_got | aw_take;
  wire w_have   = w_got | w_take;
  wire do_write = aw_have & w_have & ~s_axi_bvalid;
  wire [7:0]  wr_addr = aw_got ? aw_addr : s_axi_awaddr;
  wire [31:0] wr_data = w_got ? w_data : s_axi_wdata;
  wire        wr_lane = w_got ? w_lane0 : s_axi_wstrb[0];
  wire        r_hold  = s_axi_rvalid & ~s_axi_rready;
  // read mux
  wire [31:0] status_word = {16'h0000, 5'h00, fifo_level, stale, powered_down,
                             active_mode, use_register, sampling, busy};
  wire [31:0] rd_word =
    (s_axi_araddr == ADDR_CONTROL) ? {30'h0000_0000, control} :
    (s_axi_araddr == ADDR_STATUS)  ? status_word :
    (s_axi_araddr == ADDR_RESULT)  ? {14'h0000, fifo_out_valid, fifo_out_data} :
    (s_axi_araddr == ADDR_CONFIG)  ? {27'h0000_000, serial_cfg} : 32'h0000_0000;
  wire rd_ok = (s_axi_araddr == ADDR_CONTROL) || (s_axi_araddr == ADDR_STATUS) ||
               (s_axi_araddr == ADDR_RESULT)  || (s_axi_araddr == ADDR_CONFIG);
  wire wr_ok = (wr_addr == ADDR_CONTROL);

  // write channels, either order, one outstanding
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      aw_got <= 1'b0;
      w_got  <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0000_0000;
      w_lane0 <= 1'b0;
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
      control <= CONTROL_RESET;
    end else begin
      if (aw_take) aw_addr <= s_axi_awaddr;
      if (w_take) begin
        w_data  <= s_axi_wdata;
        w_lane0 <= s_axi_wstrb[0];
      end
      aw_got <= aw_have & ~do_write;
      w_got  <= w_have & ~do_write;
      s_axi_awready <= ~(aw_have & ~do_write);
      s_axi_wready  <= ~(w_have & ~do_write);
      if (do_write) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
        if (wr_ok && wr_lane) control <= wr_data[1:0];
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // read channel, answer one cycle after the address
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= RESP_OKAY;
    end else begin
      s_axi_arready <= ~(ar_take | r_hold);
      s_axi_rvalid  <= ar_take | r_hold;
      if (ar_take) begin
        s_axi_rdata <= rd_word;
        s_axi_rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  start_busy_a: assert property (start |=> busy && dac_code == CODE_MID)
    else $error("start did not raise busy with MSB trial");
  early_start_a: assert property (
    (start_fall && state == ST_ACQ && !acq_done) |=> state == ST_ACQ)
    else $error("start taken before acquisition finished");
  conv_len_a: assert property (start |-> ##17 state == ST_DONE)
    else $error("conversion did not take 16 bit steps");
  busy_code_a: assert property ($fell(busy) |-> result_code == $past(final_code))
    else $error("code not formed when busy fell");
  hold_code_a: assert property (!finish |=> $stable(result_code))
    else $error("result changed without a completion");
  sat_high_a: assert property (
    (finish && over_hi && active.offset_binary) |=> result_code == CODE_MAX)
    else $error("overrange high not saturated");
  twos_code_a: assert property (
    (finish && !over_hi && !over_lo && !active.offset_binary)
      |=> result_code == ($past(sar_code) ^ CODE_MID))
    else $error("twos complement code wrong");
  warp_mode_a: assert property (
    (start && sel_cfg.warp && !sel_cfg.impulse) |=> active_mode == MODE_WARP)
    else $error("warp not selected");
  normal_mode_a: assert property (
    (start && sel_cfg.warp == sel_cfg.impulse) |=> active_mode == MODE_NORMAL)
    else $error("normal not selected");
  impulse_sleep_a: assert property (
    (finish && active_mode == MODE_IMPULSE) |=> powered_down)
    else $error("impulse mode did not power down");
  cfg_apply_a: assert property (start |=> active == $past(sel_cfg))
    else $error("configuration not applied at sample");
  reg_override_a: assert property (
    (start && use_register) |=> active == $past(serial_cfg))
    else $error("pins not ignored in register mode");

  warp_conv_c:    cover property (start && next_mode == MODE_WARP ##17 finish);
  impulse_conv_c: cover property (finish && active_mode == MODE_IMPULSE);
  stale_c:        cover property (start && next_mode == MODE_WARP
                                  && since_start >= STALE_LIMIT);
  fifo_full_c:    cover property (state == ST_DONE && !fifo_in_ready);

endmodule : sar_adc_conversion_control

// File: sim/analog_core_model.sv
`timescale 1ns/1ps

// ----------------------------------------
// comparator of the analog core
// ----------------------------------------
module analog_core_model (
  input  wire logic [15:0] dac_code,       // trial code
  input  wire logic [15:0] level,          // held sample, binary
  output logic             comparator_keep // 1 keeps the trial bit
);
  // ideal comparator, so the search lands exactly on level
  assign comparator_keep = (dac_code <= level);
endmodule : analog_core_model

// File: sim/sar_adc_conversion_control_tb_top.sv
`timescale 1ns/1ps

module sar_adc_conversion_control_tb_top;
  import sar_ctrl_pkg::*;
  // ----------------------------------------
  // signals, named as the ports
  // ----------------------------------------
  logic clk, reset, convert_start_n, high_speed_select, low_power_select;
  logic coding_select, bipolar_select, span_double_select, serial_parallel_select;
  logic pins_or_register_select, cfg_sck, cfg_sdin, cfg_cs_n, comparator_keep;
  logic overrange_high, overrange_low, sampling, powered_down, busy;
  logic range_bipolar, range_span_double, hi, lo;
  logic [15:0] dac_code, result_code, lvl, ex;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd, rnd;
  logic [3:0]  s_axi_wstrb;
  logic [2:0]  me;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  int   err_count, comparisons, i;
  logic [15:0] exq[$];  // codes waiting in the result fifo

  sar_adc_conversion_control #(.STALE_LIMIT(200)) dut (.clk, .reset, .convert_start_n,
    .high_speed_select, .low_power_select, .coding_select, .bipolar_select,
    .span_double_select, .serial_parallel_select, .pins_or_register_select, .cfg_sck,
    .cfg_sdin, .cfg_cs_n, .comparator_keep, .overrange_high, .overrange_low, .dac_code,
    .sampling, .powered_down, .range_bipolar, .range_span_double, .busy, .result_code,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready);
  analog_core_model core (.dac_code, .level(lvl), .comparator_keep);

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // ----------------------------------------
  // checks and bus tasks
  // ----------------------------------------
  task chk(input string n, input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e) begin
      err_count++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task finish_test;
    $display("mismatches %0d comparisons %0d", err_count, comparisons);
    if (err_count == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : finish_test
  task tmo;
    err_count++;
    finish_test();
  endtask : tmo
  task axw(input logic [7:0] a, input logic [31:0] d);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    if (i == 50) tmo();
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge clk);
  endtask : axw
  task axr(input logic [7:0] a);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    if (i == 50) tmo();
    rd  = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge clk);
  endtask : axr
  // start pulse; overrange held across the start edge
  task conv(input logic [15:0] v, input logic h, input logic l);
    lvl <= v;
    overrange_high <= h;
    overrange_low  <= l;
    convert_start_n <= 1'b0;
    repeat (2) @(posedge clk);
    chk("busy", busy, 1'b1);
    convert_start_n <= 1'b1;
    overrange_high  <= 1'b0;
    overrange_low   <= 1'b0;
  endtask : conv
  task wdone;
    for (i = 0; i < 40 && busy !== 1'b0; i++) @(posedge clk);
    if (i == 40) tmo();
  endtask : wdone
  task pop;
    axr(ADDR_RESULT);
    chk("valid", rd[17], 1'b1);
    chk("fifo_code", rd[15:0], exq.pop_front());
  endtask : pop
  task frame(input logic [4:0] f, input int n);
    cfg_cs_n <= 1'b0;
    for (int b = 4; b > 4 - n; b--) begin
      cfg_sdin <= f[b];
      repeat (3) @(posedge clk);
      cfg_sck <= 1'b1;
      repeat (3) @(posedge clk);
      cfg_sck <= 1'b0;
    end
    repeat (3) @(posedge clk);
    cfg_cs_n <= 1'b1;
    repeat (60) @(posedge clk);
  endtask : frame
  // reference coding: saturate first, then flip msb for twos complement
  function automatic logic [15:0] code_of(logic [15:0] v, logic ob, logic h, logic l);
    logic [15:0] c;
    c = h ? 16'hFFFF : (l ? 16'h0000 : v);
    return ob ? c : c ^ 16'h8000;
  endfunction : code_of

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    {reset, convert_start_n, cfg_cs_n, coding_select} = 4'hF;
    {high_speed_select, low_power_select, bipolar_select, span_double_select} = 4'h0;
    {serial_parallel_select, pins_or_register_select, cfg_sck, cfg_sdin} = 4'h0;
    {overrange_high, overrange_low, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 5'h00;
    {s_axi_arvalid, s_axi_rready, lvl, s_axi_awaddr, s_axi_araddr} = '0;
    {s_axi_wdata, s_axi_wstrb} = {32'h0000_0000, 4'hF};
    void'($urandom(9));
    repeat (8) @(posedge clk);
    reset <= 1'b0;
    repeat (60) @(posedge clk);
    axr(ADDR_CONTROL);
    chk("control", rd[1:0], CONTROL_RESET);
    axr(8'h10);
    chk("unmapped", rsp, RESP_SLVERR);
    axw(ADDR_STATUS, 32'h0000_0000);
    chk("ro_write", rsp, RESP_SLVERR);
    // every mode pair, both codings, saturation both ways
    for (int m = 0; m < 16; m++) begin
      rnd = $urandom;
      {high_speed_select, low_power_select, coding_select} <= m[2:0];
      {bipolar_select, span_double_select} <= rnd[17:16];
      hi = m[3] & m[2];
      lo = m[3] & ~m[2];
      me = (m[2] & ~m[1]) ? 3'b010 : ((~m[2] & m[1]) ? 3'b100 : 3'b001);
      ex = code_of(rnd[15:0], m[0], hi, lo);
      conv(rnd[15:0], hi, lo);
      wdone();
      chk("result", result_code, ex);
      chk("range", {range_bipolar, range_span_double}, rnd[17:16]);
      exq.push_back(ex);
      axr(ADDR_STATUS);
      chk("mode", rd[5:3], me);
      chk("power_down", powered_down, me[2]);
      pop();
      repeat (50) @(posedge clk);
    end
    // refused start while disabled
    axw(ADDR_CONTROL, 32'h0000_0000);
    convert_start_n <= 1'b0;
    repeat (4) @(posedge clk);
    chk("busy_off", busy, 1'b0);
    convert_start_n <= 1'b1;
    axw(ADDR_CONTROL, 32'h0000_0003);
    repeat (50) @(posedge clk);
    // fill the fifo, then a fifth result stalls until a pop
    coding_select <= 1'b1;
    for (int k = 0; k < 5; k++) begin
      rnd = $urandom;
      exq.push_back(rnd[15:0]);
      conv(rnd[15:0], 1'b0, 1'b0);
      if (k < 4) wdone();
      repeat (50) @(posedge clk);
    end
    chk("stall", busy, 1'b1);
    axr(ADDR_STATUS);
    chk("level", rd[10:8], 3'd4);
    repeat (5) pop();
    chk("held", result_code, rnd[15:0]);
    // register path overrides opposite pins
    {serial_parallel_select, pins_or_register_select} <= 2'b10;
    {coding_select, high_speed_select, low_power_select} <= 3'b101;
    {bipolar_select, span_double_select} <= 2'b01;
    frame(5'b10100, 5);
    frame(5'b01011, 4);
    axr(ADDR_CONFIG);
    chk("config", rd[4:0], 5'h14);
    rnd = $urandom;
    conv(rnd[15:0], 1'b0, 1'b0);
    wdone();
    chk("reg_code", result_code, rnd[15:0] ^ 16'h8000);
    chk("reg_range", {range_bipolar, range_span_double}, 2'b10);
    axr(ADDR_STATUS);
    chk("reg_mode", rd[5:2], 4'b0101);
    chk("stale", rd[10:7], 4'b0001);
    finish_test();
  end
endmodule : sar_adc_conversion_control_tb_top
